// ### core/pin_wake_detect.sv
// Purpose: synchronise wake-capable port pins and flag enabled level changes
// Assumes: pins are asynchronous to REF_CLK_I
// Notes: edge flag is qualified by the enable vector supplied by the caller
`timescale 1ns/1ps
module pin_wake_detect #(
  parameter int NPINS = 8
) (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic [NPINS-1:0] PIN_I,
  input wire logic [NPINS-1:0] WAKE_EN_I,
  output logic [NPINS-1:0] PIN_LEVEL_O,
  output logic WAKE_O
);
  import power_mode_pkg::*;

  typedef struct packed {
    logic [NPINS-1:0] meta;
    logic [NPINS-1:0] sync;
    logic [NPINS-1:0] prev;
  } pin_state_s;

  pin_state_s st_r;
  pin_state_s st_nxt;
  logic [NPINS-1:0] hit;

  // per-pin change detect on the second flop only, either direction
  genvar g;
  generate
    for (g = 0; g < NPINS; g++) begin : g_pin
      assign hit[g] = WAKE_EN_I[g] & (st_r.sync[g] ^ st_r.prev[g]);
    end
  endgenerate

  // two-flop synchroniser then a history flop
  always_comb begin
    st_nxt = st_r;
    st_nxt.meta = PIN_I;
    st_nxt.sync = st_r.meta;
    st_nxt.prev = st_r.sync;
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign PIN_LEVEL_O = st_r.sync;
  assign WAKE_O = |hit;

endmodule

// ### core/power_mode_ctrl.sv
// Purpose: stop/halt power-mode controller with recovery reset sequencer
// Assumes: core gives one-cycle stop/halt pulses on REF_CLK_I; pins are async
// Notes: the block itself runs on the always-on reference clock
// Summary of operation
// - stop and halt instructions enter those modes
// - recovery holds reset 66 slow, 16 system
// - recovery leaves control and enables, sets flags, reloads pin data
// - core restarts from vector at 0002H
// - watchdog or pin stop wake sets stop cause
// - watchdog wake sets both cause flags
// - watchdog interrupt served after recovery if enabled
// - enabled pin change in stop wakes chip
// - pin data frozen, recorded only if persisting
// - stop kills crystal, clocks, core, counter
// - watchdog, brown-out in stop only when enabled
// - other peripherals idle during stop
// - halt keeps clocks, stops core only
// - halt exits on interrupt, watchdog or reset
`timescale 1ns/1ps
module power_mode_ctrl #(
  parameter int NPINS = power_mode_pkg::NPINS_DEF
) (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // processor core
  input wire logic STOP_INSTR_I,
  input wire logic HALT_INSTR_I,
  input wire logic INT_REQ_I,
  input wire logic WDT_INT_ACK_I,
  output logic CORE_RUN_O,
  output logic PC_HOLD_O,
  output logic CORE_RESET_O,
  output logic VECTOR_FETCH_O,
  output logic [15:0] VECTOR_ADDR_O,
  // watchdog and brown-out
  input wire logic WDT_TIMEOUT_I,
  input wire logic WDT_OSC_I,
  input wire logic BROWNOUT_I,
  output logic WDT_RUN_O,
  output logic WDT_OSC_EN_O,
  output logic VBO_EN_O,
  output logic WDT_INT_O,
  // reset pin and wake pins
  input wire logic EXT_RESET_N_I,
  input wire logic [NPINS-1:0] PIN_I,
  // clock and crystal control
  output logic XTAL_EN_O,
  output logic XIN_O,
  output logic XIN_OE_O,
  output logic XOUT_O,
  output logic XOUT_OE_O,
  output logic SYSCLK_EN_O,
  output logic PERIPH_EN_O,
  output logic IRQ_O
);
  import power_mode_pkg::*;

  typedef struct packed {
    mode_e mode;
    logic [2:0] meta;
    logic [2:0] sync;
    logic osc_prev;
    logic [6:0] slow_cnt;
    logic [4:0] sys_cnt;
    logic wake_wdt;
    logic [CTRL_W-1:0] ctrl;
    logic [NPINS-1:0] wake_en;
    logic [WD_W-1:0] wd_flags;
    logic [NPINS-1:0] pin_data;
    logic wdt_int_pend;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_en;
    logic [31:0] prdata;
    logic vec_fetch;
  } ctrl_state_s;

  ctrl_state_s st_r;
  ctrl_state_s st_nxt;

  logic [NPINS-1:0] pin_level;
  logic pin_wake;
  logic in_stop;
  logic apb_setup;
  logic apb_wr;
  logic addr_hit;
  logic osc_rise;
  logic ext_rst;
  logic vbo_rst;
  logic wdt_active;
  logic wdt_to;
  logic wdt_int_mode;
  logic sys_rst;

  // stop is the only mode in which pins may wake the chip
  assign in_stop = (st_r.mode == MODE_STOP);

  // pins are only looked at as wake sources while stopped
  pin_wake_detect #(
    .NPINS(NPINS)
  ) u_pin_wake (
    .REF_CLK_I(REF_CLK_I),
    .RST_I(RST_I),
    .PIN_I(PIN_I),
    .WAKE_EN_I(st_r.wake_en & {NPINS{in_stop}}),
    .PIN_LEVEL_O(pin_level),
    .WAKE_O(pin_wake)
  );

  // apb phase decode; the slave never inserts wait states
  assign apb_setup = PSEL_I & ~PENABLE_I;
  assign apb_wr = PSEL_I & PENABLE_I & PWRITE_I & addr_hit;

  // only the eight aligned words answer; anything else raises pslverr
  always_comb begin
    case (PADDR_I)
      ADDR_CTRL, ADDR_WAKE_EN, ADDR_WD_CTRL, ADDR_MODE,
      ADDR_PIN_DATA, ADDR_IRQ_STAT, ADDR_IRQ_CLR, ADDR_IRQ_EN: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end

  // wake and reset qualifiers; pin inputs come through the synchronisers, the watchdog timeout is used directly
  assign osc_rise = st_r.sync[SYNC_OSC] & ~st_r.osc_prev;
  assign ext_rst = ~st_r.sync[SYNC_EXTRST_N];
  assign vbo_rst = st_r.sync[SYNC_VBO] & (~in_stop | st_r.ctrl[CTRL_VBO_STOP]);
  assign sys_rst = ext_rst | vbo_rst;
  assign wdt_active = st_r.ctrl[CTRL_WDT_EN] & (~in_stop | st_r.ctrl[CTRL_WDT_STOP]);
  assign wdt_to = WDT_TIMEOUT_I & wdt_active;
  assign wdt_int_mode = st_r.ctrl[CTRL_WDT_INT];

  // whole next-state function: bus, flags, mode sequencer
  always_comb begin
    st_nxt = st_r;
    st_nxt.vec_fetch = 1'b0;

    // pin synchronisers; first stage feeds only the second
    st_nxt.meta = {BROWNOUT_I, EXT_RESET_N_I, WDT_OSC_I};
    st_nxt.sync = st_r.meta;
    st_nxt.osc_prev = st_r.sync[SYNC_OSC];

    // read data registered in the setup phase so it is stable in access
    if (apb_setup) begin
      st_nxt.prdata = 32'h0000_0000;
      case (PADDR_I)
        ADDR_CTRL: st_nxt.prdata[CTRL_W-1:0] = st_r.ctrl;
        ADDR_WAKE_EN: st_nxt.prdata[NPINS-1:0] = st_r.wake_en;
        ADDR_WD_CTRL: st_nxt.prdata[WD_W-1:0] = st_r.wd_flags;
        ADDR_MODE: st_nxt.prdata[2:0] = st_r.mode;
        ADDR_PIN_DATA: st_nxt.prdata[NPINS-1:0] = st_r.pin_data;
        ADDR_IRQ_STAT: st_nxt.prdata[IRQ_W-1:0] = st_r.irq_stat;
        ADDR_IRQ_EN: st_nxt.prdata[IRQ_W-1:0] = st_r.irq_en;
        default: st_nxt.prdata = 32'h0000_0000;
      endcase
    end

    // software writes; clears come first so a same-cycle hardware set wins
    if (apb_wr) begin
      case (PADDR_I)
        ADDR_CTRL: st_nxt.ctrl = PWDATA_I[CTRL_W-1:0];
        ADDR_WAKE_EN: st_nxt.wake_en = PWDATA_I[NPINS-1:0];
        ADDR_WD_CTRL: st_nxt.wd_flags = st_r.wd_flags & ~PWDATA_I[WD_W-1:0];
        ADDR_IRQ_CLR: st_nxt.irq_stat = st_r.irq_stat & ~PWDATA_I[IRQ_W-1:0];
        ADDR_IRQ_EN: st_nxt.irq_en = PWDATA_I[IRQ_W-1:0];
        default: st_nxt.ctrl = st_r.ctrl;
      endcase
    end

    // core takes the pending watchdog interrupt
    if (WDT_INT_ACK_I) begin
      st_nxt.wdt_int_pend = 1'b0;
    end

    // port data follows pins while awake, frozen in stop and recovery
    if ((st_r.mode == MODE_RUN) || (st_r.mode == MODE_HALT)) begin
      st_nxt.pin_data = pin_level;
      if (pin_level != st_r.pin_data) begin
        st_nxt.irq_stat[IRQ_PIN] = 1'b1;
      end
    end

    case (st_r.mode)
      MODE_RUN: begin
        // resets first, then a watchdog interrupt, then the core's instruction
        if (sys_rst || (wdt_to && !wdt_int_mode)) begin
          st_nxt.mode = MODE_RECOV_SLOW;
          st_nxt.slow_cnt = 7'h00;
          st_nxt.wake_wdt = 1'b0;
        end else begin
          if (wdt_to) begin
            st_nxt.wdt_int_pend = 1'b1;
          end
          if (STOP_INSTR_I) begin
            st_nxt.mode = MODE_STOP;
            st_nxt.irq_stat[IRQ_STOP] = 1'b1;
          end else if (HALT_INSTR_I) begin
            st_nxt.mode = MODE_HALT;
            st_nxt.irq_stat[IRQ_HALT] = 1'b1;
          end
        end
      end
      MODE_HALT: begin
        // resets restart the chip, interrupts just resume the core
        if (sys_rst || (wdt_to && !wdt_int_mode)) begin
          st_nxt.mode = MODE_RECOV_SLOW;
          st_nxt.slow_cnt = 7'h00;
          st_nxt.wake_wdt = 1'b0;
        end else if (INT_REQ_I || wdt_to) begin
          st_nxt.mode = MODE_RUN;
          if (wdt_to) begin
            st_nxt.wdt_int_pend = 1'b1;
          end
        end
      end
      MODE_STOP: begin
        // reset pin beats the watchdog, which beats a pin change
        if (sys_rst) begin
          st_nxt.mode = MODE_RECOV_SLOW;
          st_nxt.slow_cnt = 7'h00;
          st_nxt.wake_wdt = 1'b0;
        end else if (wdt_to) begin
          st_nxt.mode = MODE_RECOV_SLOW;
          st_nxt.slow_cnt = 7'h00;
          // watchdog wake marks both causes, whatever its configuration
          st_nxt.wake_wdt = 1'b1;
          st_nxt.wd_flags[WD_WDT_BIT] = 1'b1;
          st_nxt.wd_flags[WD_STOP_BIT] = 1'b1;
        end else if (pin_wake) begin
          st_nxt.mode = MODE_RECOV_SLOW;
          st_nxt.slow_cnt = 7'h00;
          st_nxt.wake_wdt = 1'b0;
          st_nxt.wd_flags[WD_STOP_BIT] = 1'b1;
        end
      end
      MODE_RECOV_SLOW: begin
        // count slow oscillator edges; a fresh reset restarts the count
        if (sys_rst) begin
          st_nxt.slow_cnt = 7'h00;
        end else if (osc_rise) begin
          st_nxt.slow_cnt = st_r.slow_cnt + 7'h01;
          if (st_r.slow_cnt == RECOV_SLOW_CYCLES - 7'h01) begin
            st_nxt.mode = MODE_RECOV_SYS;
            st_nxt.sys_cnt = 5'h00;
          end
        end
      end
      MODE_RECOV_SYS: begin
        // reset pin or brown-out here starts again from the slow phase
        if (sys_rst) begin
          st_nxt.mode = MODE_RECOV_SLOW;
          st_nxt.slow_cnt = 7'h00;
        end else begin
          st_nxt.sys_cnt = st_r.sys_cnt + 5'h01;
          // release only after both counts have run out
          if (st_r.sys_cnt == RECOV_SYS_CYCLES - 5'h01) begin
            st_nxt.mode = MODE_RUN;
            st_nxt.vec_fetch = 1'b1;
            st_nxt.irq_stat[IRQ_RECOV] = 1'b1;
            // only a level still present now reaches the port data
            st_nxt.pin_data = pin_level;
            if (pin_level != st_r.pin_data) begin
              st_nxt.irq_stat[IRQ_PIN] = 1'b1;
            end
            if (st_r.wake_wdt && wdt_int_mode) begin
              st_nxt.wdt_int_pend = 1'b1;
            end
          end
        end
      end
      default: begin
        // an illegal code falls back to run rather than locking up
        st_nxt.mode = MODE_RUN;
      end
    endcase
  end

  // ctrl and enables are not touched by recovery; pin data is reloaded at its end, flags set
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      st_r.mode <= MODE_RUN;
      st_r.meta <= SYNC_RST;
      st_r.sync <= SYNC_RST;
      st_r.osc_prev <= 1'b0;
      st_r.slow_cnt <= 7'h00;
      st_r.sys_cnt <= 5'h00;
      st_r.wake_wdt <= 1'b0;
      st_r.ctrl <= CTRL_RST;
      st_r.wake_en <= '0;
      st_r.wd_flags <= WD_RST;
      st_r.pin_data <= '0;
      st_r.wdt_int_pend <= 1'b0;
      st_r.irq_stat <= IRQ_RST;
      st_r.irq_en <= IRQ_RST;
      st_r.prdata <= 32'h0000_0000;
      st_r.vec_fetch <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // apb answers
  assign PRDATA_O = st_r.prdata;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I & PENABLE_I & ~addr_hit;

  // core control; the core is held in reset across both recovery phases
  assign CORE_RUN_O = (st_r.mode == MODE_RUN);
  assign PC_HOLD_O = (st_r.mode != MODE_RUN);
  assign CORE_RESET_O = (st_r.mode == MODE_RECOV_SLOW) || (st_r.mode == MODE_RECOV_SYS);
  assign VECTOR_FETCH_O = st_r.vec_fetch;
  assign VECTOR_ADDR_O = RESET_VECTOR_ADDR;

  // crystal stopped in stop with its pins parked high and low
  assign XTAL_EN_O = ~in_stop;
  assign XIN_O = 1'b1;
  assign XIN_OE_O = in_stop;
  assign XOUT_O = 1'b0;
  assign XOUT_OE_O = in_stop;
  // system clock waits for the slow count, as after a reset pin or brown-out
  assign SYSCLK_EN_O = ~in_stop & (st_r.mode != MODE_RECOV_SLOW);
  assign PERIPH_EN_O = (st_r.mode == MODE_RUN) || (st_r.mode == MODE_HALT);

  // watchdog and brown-out keep going in stop only when allowed
  assign WDT_RUN_O = wdt_active;
  assign WDT_OSC_EN_O = ~in_stop | st_r.ctrl[CTRL_WDT_STOP];
  assign VBO_EN_O = ~in_stop | st_r.ctrl[CTRL_VBO_STOP];
  assign WDT_INT_O = st_r.wdt_int_pend & st_r.ctrl[CTRL_INT_EN];

  // level interrupt while any enabled status bit is set
  assign IRQ_O = |(st_r.irq_stat & st_r.irq_en);

endmodule

// ### core/power_mode_pkg.sv
// Purpose: shared constants and types for the stop/halt power-mode controller
// Assumes: 32-bit APB register bus, one reference clock
// Notes: offsets are byte addresses of aligned words
package power_mode_pkg;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_WAKE_EN = 8'h04;
  localparam logic [7:0] ADDR_WD_CTRL = 8'h08;
  localparam logic [7:0] ADDR_MODE = 8'h0C;
  localparam logic [7:0] ADDR_PIN_DATA = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h18;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h1C;

  // control register fields
  localparam int CTRL_W = 5;
  localparam int CTRL_WDT_EN = 0;
  localparam int CTRL_WDT_STOP = 1;
  localparam int CTRL_VBO_STOP = 2;
  localparam int CTRL_WDT_INT = 3;
  localparam int CTRL_INT_EN = 4;
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;

  // watchdog control register cause flags
  localparam int WD_W = 2;
  localparam int WD_STOP_BIT = 0;
  localparam int WD_WDT_BIT = 1;
  localparam logic [WD_W-1:0] WD_RST = 2'h0;

  // interrupt status, clear and enable layout
  localparam int IRQ_W = 4;
  localparam int IRQ_STOP = 0;
  localparam int IRQ_HALT = 1;
  localparam int IRQ_RECOV = 2;
  localparam int IRQ_PIN = 3;
  localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;

  // recovery counts and reset vector
  localparam logic [6:0] RECOV_SLOW_CYCLES = 7'h42;
  localparam logic [4:0] RECOV_SYS_CYCLES = 5'h10;
  localparam logic [15:0] RESET_VECTOR_ADDR = 16'h0002;

  // pin synchroniser slots: slow oscillator, reset pin (low active), brown-out
  localparam int SYNC_OSC = 0;
  localparam int SYNC_EXTRST_N = 1;
  localparam int SYNC_VBO = 2;
  localparam logic [2:0] SYNC_RST = 3'h2;

  localparam int NPINS_DEF = 8;

  typedef enum logic [2:0] {
    MODE_RUN,
    MODE_HALT,
    MODE_STOP,
    MODE_RECOV_SLOW,
    MODE_RECOV_SYS
  } mode_e;

endpackage

// ### test/low_power_stop_recovery_tb.sv
// Purpose: directed scenarios for stop, halt and recovery
// Assumes: crystal clocking only, so stop is always legal here
// Notes: every wait is bounded by the watchdog process
`timescale 1ns/1ps
module low_power_stop_recovery_tb;
  import power_mode_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic stop_p = 1'b0, halt_p = 1'b0, int_req = 1'b0, wdt_ack = 1'b0, wdt_to = 1'b0;
  logic brown = 1'b0, ext_rst_n = 1'b1, se, osc;
  logic [7:0] pins = 8'h00;
  logic pready, pslverr, core_run, pc_hold, core_rst, vec_fetch, wdt_run, osc_en, vbo_en, wdt_int;
  logic xtal_en, xin, xin_oe, xout, xout_oe, sysclk_en, periph_en, irq;
  logic [15:0] vec_addr;
  int err_count = 0;
  int check_count = 0;

  // 10 MHz reference
  always #50 clk = ~clk;

  power_mode_ctrl #(.NPINS(8)) dut_u (
    .REF_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .STOP_INSTR_I(stop_p), .HALT_INSTR_I(halt_p), .INT_REQ_I(int_req), .WDT_INT_ACK_I(wdt_ack),
    .CORE_RUN_O(core_run), .PC_HOLD_O(pc_hold), .CORE_RESET_O(core_rst), .VECTOR_FETCH_O(vec_fetch),
    .VECTOR_ADDR_O(vec_addr), .WDT_TIMEOUT_I(wdt_to), .WDT_OSC_I(osc), .BROWNOUT_I(brown),
    .WDT_RUN_O(wdt_run), .WDT_OSC_EN_O(osc_en), .VBO_EN_O(vbo_en), .WDT_INT_O(wdt_int),
    .EXT_RESET_N_I(ext_rst_n), .PIN_I(pins), .XTAL_EN_O(xtal_en), .XIN_O(xin), .XIN_OE_O(xin_oe),
    .XOUT_O(xout), .XOUT_OE_O(xout_oe), .SYSCLK_EN_O(sysclk_en), .PERIPH_EN_O(periph_en), .IRQ_O(irq)
  );

  wdt_osc_model osc_u (.enable_i(osc_en), .osc_o(osc));

  task finish_test;
    if (err_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    check(rd, exp);
  endtask

  task enter_stop;
    @(posedge clk);
    stop_p <= 1'b1;
    @(posedge clk);
    stop_p <= 1'b0;
    @(negedge clk);
    check({xtal_en, xin, xin_oe, xout, xout_oe, sysclk_en, periph_en, pc_hold, core_run}, 9'h0D2);
  endtask

  // waits out both recovery phases and counts the system-clock one
  task recover(input logic [31:0] cause);
    int n;
    n = 0;
    while (core_rst !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    check({core_rst, sysclk_en}, 2'h2);
    while (sysclk_en !== 1'b1) @(negedge clk);
    n = 0;
    while (core_rst === 1'b1) begin
      @(negedge clk);
      n++;
    end
    check(n, 32'h10);
    check({vec_fetch, vec_addr}, 17'h10002);
    rdchk(ADDR_WD_CTRL, cause);
  endtask

  task t_reset_regs;
    @(negedge clk);
    check({core_run, pc_hold, core_rst, xtal_en, sysclk_en, periph_en, irq, pready}, 8'h9D);
    rdchk(ADDR_CTRL, 32'h0);
    apb(8'h20, 1'b0, 32'h0);
    check(se, 1'b1);
    check(rd, 32'h0);
    apb(ADDR_MODE, 1'b1, 32'h3);
    rdchk(ADDR_MODE, 32'h0);
    apb(ADDR_WAKE_EN, 1'b1, 32'hFFFFFFFF);
    rdchk(ADDR_WAKE_EN, 32'hFF);
  endtask

  task t_halt;
    @(posedge clk);
    halt_p <= 1'b1;
    @(posedge clk);
    halt_p <= 1'b0;
    @(negedge clk);
    check({xtal_en, sysclk_en, periph_en, pc_hold, core_run}, 5'h1E);
    rdchk(ADDR_MODE, 32'h1);
    int_req <= 1'b1;
    @(posedge clk);
    int_req <= 1'b0;
    @(negedge clk);
    check(core_run, 1'b1);
    @(posedge clk);
    halt_p <= 1'b1;
    @(posedge clk);
    halt_p <= 1'b0;
    ext_rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    ext_rst_n <= 1'b1;
    recover(32'h0);
  endtask

  task t_stop_pin(input logic short_pulse);
    apb(ADDR_CTRL, 1'b1, 32'h0);
    apb(ADDR_WAKE_EN, 1'b1, 32'h1);
    apb(ADDR_IRQ_EN, 1'b1, 32'hF);
    apb(ADDR_IRQ_CLR, 1'b1, 32'hF);
    enter_stop;
    check({wdt_run, vbo_en, irq}, 3'h1);
    @(posedge clk);
    pins[1] <= 1'b1;
    repeat (10) @(negedge clk);
    check({core_rst, xin_oe}, 2'h1);
    @(posedge clk);
    pins[0] <= 1'b1;
    if (short_pulse) begin
      repeat (4) @(posedge clk);
      pins[0] <= 1'b0;
    end
    recover(32'h1);
    rdchk(ADDR_PIN_DATA, short_pulse ? 32'h2 : 32'h3);
    rdchk(ADDR_WAKE_EN, 32'h1);
    apb(ADDR_IRQ_STAT, 1'b0, 32'h0);
    check(rd & 32'h7, 32'h5);
    apb(ADDR_IRQ_EN, 1'b1, 32'h0);
    @(negedge clk);
    check(irq, 1'b0);
    apb(ADDR_IRQ_EN, 1'b1, 32'hF);
    apb(ADDR_IRQ_CLR, 1'b1, 32'hF);
    @(negedge clk);
    check(irq, 1'b0);
    apb(ADDR_WD_CTRL, 1'b1, 32'h3);
    rdchk(ADDR_WD_CTRL, 32'h0);
    pins <= 8'h00;
  endtask

  task t_stop_wdt;
    apb(ADDR_CTRL, 1'b1, 32'h1B);
    enter_stop;
    check({wdt_run, osc_en, vbo_en}, 3'h6);
    @(posedge clk);
    wdt_to <= 1'b1;
    @(posedge clk);
    wdt_to <= 1'b0;
    recover(32'h3);
    check(wdt_int, 1'b1);
    rdchk(ADDR_CTRL, 32'h1B);
    wdt_ack <= 1'b1;
    @(posedge clk);
    wdt_ack <= 1'b0;
    @(negedge clk);
    check(wdt_int, 1'b0);
  endtask

  // brown-out ignored in stop while not allowed, then plain recoveries from run
  task t_brownout;
    apb(ADDR_WD_CTRL, 1'b1, 32'h3);
    enter_stop;
    @(posedge clk);
    brown <= 1'b1;
    repeat (6) @(posedge clk);
    brown <= 1'b0;
    @(negedge clk);
    check({core_rst, xin_oe}, 2'h1);
    @(posedge clk);
    wdt_to <= 1'b1;
    @(posedge clk);
    wdt_to <= 1'b0;
    recover(32'h3);
    apb(ADDR_WD_CTRL, 1'b1, 32'h3);
    @(posedge clk);
    brown <= 1'b1;
    repeat (3) @(posedge clk);
    brown <= 1'b0;
    recover(32'h0);
    apb(ADDR_CTRL, 1'b1, 32'h1);
    wdt_to <= 1'b1;
    @(posedge clk);
    wdt_to <= 1'b0;
    recover(32'h0);
  endtask

  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset_regs;
    t_halt;
    t_stop_pin(1'b0);
    t_stop_pin(1'b1);
    t_stop_wdt;
    t_brownout;
    finish_test;
  end

  // hang guard, several times the longest expected run
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    finish_test;
  end
endmodule

// ### test/power_mode_checker_assertions.sv
// Purpose: port-level checks for the power-mode controller
// Assumes: one REF_CLK_I domain, RST_I async active high
// Notes: osc and reset pin synced by two flops, as in the block
`timescale 1ns/1ps
module power_mode_checker (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic STOP_INSTR_I,
  input wire logic HALT_INSTR_I,
  input wire logic INT_REQ_I,
  input wire logic WDT_TIMEOUT_I,
  input wire logic WDT_OSC_I,
  input wire logic BROWNOUT_I,
  input wire logic EXT_RESET_N_I,
  input wire logic CORE_RUN_O,
  input wire logic PC_HOLD_O,
  input wire logic CORE_RESET_O,
  input wire logic VECTOR_FETCH_O,
  input wire logic [15:0] VECTOR_ADDR_O,
  input wire logic XTAL_EN_O,
  input wire logic XIN_O,
  input wire logic XIN_OE_O,
  input wire logic XOUT_O,
  input wire logic XOUT_OE_O,
  input wire logic SYSCLK_EN_O,
  input wire logic PERIPH_EN_O
);
  logic [2:0] osc_q;
  logic [1:0] ok_q;
  logic [6:0] slow_cnt;
  logic [4:0] sys_cnt;

  // per-phase counts; a reset pin mid-recovery restarts the slow count
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      osc_q <= 3'h0;
      ok_q <= 2'h3;
      slow_cnt <= 7'h00;
      sys_cnt <= 5'h00;
    end else begin
      osc_q <= {osc_q[1:0], WDT_OSC_I};
      ok_q <= {ok_q[0], EXT_RESET_N_I & !BROWNOUT_I};
      slow_cnt <= (!CORE_RESET_O || !ok_q[1]) ? 7'h00 : slow_cnt + {6'h00, osc_q[1] & !osc_q[2] & !SYSCLK_EN_O};
      sys_cnt <= (CORE_RESET_O && SYSCLK_EN_O) ? sys_cnt + 5'h01 : 5'h00;
    end
  end

  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (RST_I);

  stop_entry_a: assert property (ok_q[1] && CORE_RUN_O && STOP_INSTR_I && !WDT_TIMEOUT_I |=>
    !XTAL_EN_O && !SYSCLK_EN_O && !PERIPH_EN_O && PC_HOLD_O) else $error("stop entry wrong");
  halt_entry_a: assert property (ok_q[1] && CORE_RUN_O && HALT_INSTR_I && !STOP_INSTR_I
    && !WDT_TIMEOUT_I |=> PERIPH_EN_O && !CORE_RUN_O && PC_HOLD_O) else $error("halt entry wrong");
  halt_clocks_a: assert property (PERIPH_EN_O && !CORE_RUN_O |-> XTAL_EN_O && SYSCLK_EN_O)
    else $error("halt clocks stopped");
  xtal_pins_a: assert property (XIN_OE_O |-> XIN_O && !XOUT_O && XOUT_OE_O && !XTAL_EN_O && !SYSCLK_EN_O)
    else $error("crystal pins wrong in stop");
  recov_hold_a: assert property (CORE_RESET_O |-> PC_HOLD_O && !CORE_RUN_O && !PERIPH_EN_O)
    else $error("core free during recovery");
  slow_count_a: assert property ($rose(SYSCLK_EN_O) && CORE_RESET_O |-> slow_cnt == 7'h42)
    else $error("slow phase length wrong");
  sys_count_a: assert property ($fell(CORE_RESET_O) |-> sys_cnt == 5'h10)
    else $error("system phase length wrong");
  vector_fetch_a: assert property ($fell(CORE_RESET_O) |->
    VECTOR_FETCH_O && CORE_RUN_O && VECTOR_ADDR_O == 16'h0002 ##1 !VECTOR_FETCH_O) else $error("vector fetch wrong");
  run_hold_a: assert property ((EXT_RESET_N_I && !BROWNOUT_I) [*4] ##0
    (CORE_RUN_O && !STOP_INSTR_I && !HALT_INSTR_I && !WDT_TIMEOUT_I) |=> CORE_RUN_O) else $error("run left");
  clock_gate_a: assert property (!SYSCLK_EN_O |-> !PERIPH_EN_O && !CORE_RUN_O)
    else $error("peripherals on without clock");
  halt_exit_a: assert property (PERIPH_EN_O && !CORE_RUN_O && INT_REQ_I |-> ##[1:2] CORE_RUN_O)
    else $error("halt not left on interrupt");
endmodule

bind power_mode_ctrl power_mode_checker chk_u (
  .REF_CLK_I, .RST_I, .STOP_INSTR_I, .HALT_INSTR_I, .INT_REQ_I, .WDT_TIMEOUT_I, .WDT_OSC_I,
  .BROWNOUT_I, .EXT_RESET_N_I, .CORE_RUN_O, .PC_HOLD_O, .CORE_RESET_O, .VECTOR_FETCH_O,
  .VECTOR_ADDR_O, .XTAL_EN_O, .XIN_O, .XIN_OE_O, .XOUT_O, .XOUT_OE_O, .SYSCLK_EN_O, .PERIPH_EN_O
);

// ### test/wdt_osc_model.sv
// Purpose: slow watchdog oscillator beside the power-mode controller
// Assumes: runs only while the block enables it
// Notes: half period unrelated in phase to the reference clock
`timescale 1ns/1ps
module wdt_osc_model (
  input wire logic enable_i,
  output logic osc_o
);
  // parks low when gated off, so no stale edge survives a stop
  initial begin
    osc_o = 1'b0;
    forever begin
      #530;
      osc_o = enable_i ? ~osc_o : 1'b0;
    end
  end
endmodule
